// ---- design/hmap_params.svh ----
// constants of the host memory access port: map, fields, timing
// assumes a 200 MHz pclk shared by both ends of the link
`ifndef HMAP_PARAMS_SVH
`define HMAP_PARAMS_SVH

`define HMAP_CLK_PS          5000
`define HMAP_OVL_ADDR        14'h3FE7
`define HMAP_OVL_SRO_BIT     14
`define HMAP_OVL_RESET       16'h0000
`define HMAP_AW_DM_BIT       14
`define HMAP_T_LATCH_NS      10
`define HMAP_T_STROBE_NS     10
`define HMAP_LATCH_CYC       ((`HMAP_T_LATCH_NS * 1000 + `HMAP_CLK_PS - 1) / `HMAP_CLK_PS)
`define HMAP_STROBE_CYC      ((`HMAP_T_STROBE_NS * 1000 + `HMAP_CLK_PS - 1) / `HMAP_CLK_PS)
`define HMAP_WR_ACK_HALF_CK  3
`define HMAP_WR_ACK_CYC      ((`HMAP_WR_ACK_HALF_CK + 1) / 2)
`define HMAP_HOLD_DM_CK      2
`define HMAP_HOLD_PM2_CK     1
`define HMAP_BUS_IDLE        16'hFFFF
`define HMAP_REG_CMD         12'h000
`define HMAP_REG_ARG         12'h004
`define HMAP_REG_RDATA       12'h008
`define HMAP_REG_STATUS      12'h00C
`define HMAP_CMD_LATCH       2'h1
`define HMAP_CMD_WRITE       2'h2
`define HMAP_CMD_READ        2'h3

`endif

// ---- design/hmap_pkg.sv ----
// types shared by both ends of the host memory access port
// assumes hmap_params.svh is compiled alongside
package hmap_pkg;

  typedef enum logic [2:0] {
    HMAP_D_IDLE  = 3'h0,
    HMAP_D_WRITE = 3'h1,
    HMAP_D_WWAIT = 3'h3,
    HMAP_D_READ  = 3'h4,
    HMAP_D_RWAIT = 3'h6
  } hmap_dev_state_t;

  typedef enum logic [2:0] {
    HMAP_H_IDLE    = 3'h0,
    HMAP_H_WAITACK = 3'h1,
    HMAP_H_STROBE  = 3'h3,
    HMAP_H_ACKW    = 3'h2,
    HMAP_H_END     = 3'h6
  } hmap_host_state_t;

endpackage

// ---- design/hmap_if.sv ----
// pins of the host memory access port between host and device
// assumes both parties clocked by one pclk; bus idles high (pull-up)
`include "hmap_params.svh"

interface hmap_if;
  logic        host_port_select_n;
  logic        host_write_strobe_n;
  logic        host_read_strobe_n;
  logic        host_address_latch;
  logic        host_acknowledge_n;
  logic [15:0] host_ad_out;
  logic        host_ad_oe_n;
  logic [15:0] dev_ad_out;
  logic        dev_ad_oe_n;
  logic [15:0] host_addr_data_bus;

  // contention resolves to the device; should never happen
  assign host_addr_data_bus = !dev_ad_oe_n ? dev_ad_out :
                              !host_ad_oe_n ? host_ad_out : `HMAP_BUS_IDLE;

  modport device (
    input  host_port_select_n,
    input  host_write_strobe_n,
    input  host_read_strobe_n,
    input  host_address_latch,
    input  host_addr_data_bus,
    output host_acknowledge_n,
    output dev_ad_out,
    output dev_ad_oe_n
  );

  modport host (
    output host_port_select_n,
    output host_write_strobe_n,
    output host_read_strobe_n,
    output host_address_latch,
    output host_ad_out,
    output host_ad_oe_n,
    input  host_addr_data_bus,
    input  host_acknowledge_n
  );
endinterface

// ---- design/hmap_device.sv ----
// device end of the host memory access port with its own memories
// assumes pins synchronous to pclk; strap stable around reset release
`include "hmap_params.svh"

// Function
// - select and write strobe low start write
// - host waits acknowledge low before reading
// - acknowledge goes high once read starts
// - read spans select and read strobe low
// - long read: word before acknowledge, held
// - read start drives previously fetched word
// - program word in halves; hold two/one
// - plain short reads need brief strobes
// - prefer short-read-only over plain short
// - overlay register bit 14 enables short-only
// - core and host both write overlay
// - short-read-only cleared after reset
// - short-only keeps previous word until end
// - strap one enables host port pins
// - strap captured at reset release
// - address latch while select low, latch high
// - long write acknowledge low after 1.5 periods; here after 2 pclk periods
module hmap_device #(
  parameter int DEPTH = 256
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  hmap_if.device           link,
  input  wire logic        mode_strap,
  input  wire logic        core_ovl_wr,
  input  wire logic [15:0] core_ovl_wdata,
  output logic      [15:0] ovl_value,
  output logic             port_enabled,
  output logic             port_busy
);
  localparam int IW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 16384 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("hmap_device: DEPTH must be a power of two, 2..16384");
  end

  typedef struct packed {
    hmap_pkg::hmap_dev_state_t state;
    logic                      strap_done;
    logic                      mode_c;
    logic [15:0]               ovl;
    logic [13:0]               addr;
    logic                      dm_sel;
    logic                      half;
    logic [15:0]               pm_upper;
    logic [15:0]               prev;
    logic [15:0]               fetched;
    logic [15:0]               drive;
    logic                      drive_en;
    logic                      ack_n;
    logic [1:0]                cnt;
    logic [1:0]                hold;
    logic                      wdone;
    logic [15:0]               wdata;
    logic                      wr_prev;
    logic                      rd_prev;
  } hmap_dev_regs_t;

  hmap_dev_regs_t r;
  hmap_dev_regs_t next_r;

  logic [15:0] dm_mem [DEPTH];
  logic [23:0] pm_mem [DEPTH];

  logic          wr_act;
  logic          rd_act;
  logic          al_act;
  logic [IW-1:0] idx;
  logic [15:0]   rd_word;
  logic          dm_we;
  logic          pm_we;
  logic [15:0]   commit_data;
  logic          commit;
  logic          sro;

  assign wr_act = r.mode_c && !link.host_port_select_n
                  && !link.host_write_strobe_n;
  assign rd_act = r.mode_c && !link.host_port_select_n
                  && !link.host_read_strobe_n;
  assign al_act = r.mode_c && !link.host_port_select_n
                  && link.host_address_latch;
  assign idx    = r.addr[IW-1:0];
  assign sro    = r.ovl[`HMAP_OVL_SRO_BIT];

  // the overlay register answers in data space ahead of the memory
  always_comb
  begin
    if (r.dm_sel)
    begin
      rd_word = (r.addr == `HMAP_OVL_ADDR) ? r.ovl : dm_mem[idx];
    end
    else if (r.half)
    begin
      rd_word = {8'h00, pm_mem[idx][7:0]};
    end
    else
    begin
      rd_word = pm_mem[idx][23:8];
    end
  end

  always_comb
  begin
    next_r      = r;
    commit      = 1'b0;
    commit_data = r.wdata;
    dm_we       = 1'b0;
    pm_we       = 1'b0;
    next_r.wr_prev = wr_act;
    next_r.rd_prev = rd_act;
    if (!r.strap_done)
    begin
      next_r.strap_done = 1'b1;
      next_r.mode_c     = mode_strap;
      next_r.ack_n      = !mode_strap;
    end
    if (core_ovl_wr)
    begin
      next_r.ovl = core_ovl_wdata;
    end
    unique case (r.state)
      hmap_pkg::HMAP_D_IDLE:
      begin
        if (al_act)
        begin
          next_r.addr   = link.host_addr_data_bus[13:0];
          next_r.dm_sel = link.host_addr_data_bus[`HMAP_AW_DM_BIT];
          next_r.half   = 1'b0;
        end
        else if (wr_act && !r.wr_prev)
        begin
          next_r.state = hmap_pkg::HMAP_D_WRITE;
          next_r.ack_n = 1'b1;
          next_r.cnt   = 2'h1;
          next_r.wdone = 1'b0;
        end
        else if (rd_act && !r.rd_prev)
        begin
          next_r.state    = hmap_pkg::HMAP_D_READ;
          next_r.ack_n    = 1'b1;
          next_r.drive    = r.prev;
          next_r.drive_en = 1'b1;
          next_r.fetched  = rd_word;
          next_r.cnt      = 2'h1;
          next_r.hold     = (!r.dm_sel && r.half) ?
                            2'(`HMAP_HOLD_PM2_CK) :
                            2'(`HMAP_HOLD_DM_CK);
          next_r.half     = !r.dm_sel && !r.half;
          if (r.dm_sel || r.half)
          begin
            next_r.addr = r.addr + 14'h0001;
          end
        end
      end
      hmap_pkg::HMAP_D_WRITE:
      begin
        next_r.cnt = r.cnt + 2'h1;
        if (!wr_act && !r.wdone)
        begin
          next_r.wdone = 1'b1;
          next_r.wdata = link.host_addr_data_bus;
        end
        if (r.cnt == 2'(`HMAP_WR_ACK_CYC))
        begin
          // short write already ended: store what it left on the bus
          next_r.ack_n = 1'b0;
          if (r.wdone || !wr_act)
          begin
            commit      = 1'b1;
            commit_data = r.wdone ? r.wdata : link.host_addr_data_bus;
            next_r.state = hmap_pkg::HMAP_D_IDLE;
          end
          else
          begin
            next_r.state = hmap_pkg::HMAP_D_WWAIT;
          end
        end
      end
      hmap_pkg::HMAP_D_WWAIT:
      begin
        if (!wr_act)
        begin
          commit       = 1'b1;
          commit_data  = link.host_addr_data_bus;
          next_r.state = hmap_pkg::HMAP_D_IDLE;
        end
      end
      hmap_pkg::HMAP_D_READ:
      begin
        next_r.cnt = r.cnt + 2'h1;
        if (!rd_act)
        begin
          // strobe ended early: data is already fetched, nothing lost
          next_r.drive_en = 1'b0;
          next_r.prev     = r.fetched;
          next_r.ack_n    = 1'b0;
          next_r.state    = hmap_pkg::HMAP_D_IDLE;
        end
        else
        begin
          if (r.cnt == r.hold && !sro)
          begin
            next_r.drive = r.fetched;
          end
          if (r.cnt > r.hold)
          begin
            next_r.ack_n = 1'b0;
            next_r.state = hmap_pkg::HMAP_D_RWAIT;
          end
        end
      end
      hmap_pkg::HMAP_D_RWAIT:
      begin
        if (!rd_act)
        begin
          next_r.drive_en = 1'b0;
          next_r.prev     = r.fetched;
          next_r.state    = hmap_pkg::HMAP_D_IDLE;
        end
      end
      default:
      begin
        next_r.state = hmap_pkg::HMAP_D_IDLE;
      end
    endcase
    if (commit)
    begin
      if (r.dm_sel)
      begin
        next_r.addr = r.addr + 14'h0001;
        if (r.addr == `HMAP_OVL_ADDR)
        begin
          next_r.ovl = commit_data;
        end
        else
        begin
          dm_we = 1'b1;
        end
      end
      else if (!r.half)
      begin
        next_r.pm_upper = commit_data;
        next_r.half     = 1'b1;
      end
      else
      begin
        pm_we       = 1'b1;
        next_r.half = 1'b0;
        next_r.addr = r.addr + 14'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r       <= '0;
      r.ovl   <= `HMAP_OVL_RESET;
      r.ack_n <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // memories carry no reset; contents are undefined until written
  always_ff @(posedge pclk)
  begin
    if (dm_we)
    begin
      dm_mem[idx] <= commit_data;
    end
    if (pm_we)
    begin
      pm_mem[idx] <= {r.pm_upper, commit_data[7:0]};
    end
  end

  assign link.host_acknowledge_n = r.ack_n;
  assign link.dev_ad_out         = r.drive;
  assign link.dev_ad_oe_n        = !r.drive_en;
  assign ovl_value               = r.ovl;
  assign port_enabled            = r.mode_c;
  assign port_busy               = r.state != hmap_pkg::HMAP_D_IDLE;
endmodule

// ---- design/hmap_host.sv ----
// host end of the port: APB-commanded controller driving the pins
// assumes an APB master on pclk and the device on the same clock
`include "hmap_params.svh"

module hmap_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  hmap_if.host             link
);
  typedef struct packed {
    hmap_pkg::hmap_host_state_t state;
    logic [1:0]                 cmd;
    logic [15:0]                arg;
    logic [15:0]                rdata;
    logic [1:0]                 cnt;
    logic [31:0]                prdata;
    logic                       pslverr;
    logic                       sel_n;
    logic                       wr_n;
    logic                       rd_n;
    logic                       al;
    logic                       oe_n;
  } hmap_host_regs_t;

  hmap_host_regs_t r;
  hmap_host_regs_t next_r;
  logic            setup;
  logic            access;

  assign setup  = psel && !penable;
  assign access = psel && penable;

  always_comb
  begin
    next_r = r;
    if (setup)
    begin
      next_r.pslverr = 1'b0;
      unique case (paddr)
        `HMAP_REG_CMD:    next_r.prdata = {30'h0, r.cmd};
        `HMAP_REG_ARG:    next_r.prdata = {16'h0, r.arg};
        `HMAP_REG_RDATA:  next_r.prdata = {16'h0, r.rdata};
        `HMAP_REG_STATUS: next_r.prdata =
                            {31'h0, r.state != hmap_pkg::HMAP_H_IDLE};
        default:
        begin
          next_r.prdata  = 32'h0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    unique case (r.state)
      hmap_pkg::HMAP_H_IDLE:
      begin
        next_r.oe_n = 1'b1;
        // a command while busy is dropped; software polls status first
        if (access && pwrite && paddr == `HMAP_REG_CMD
            && pwdata[1:0] != 2'h0)
        begin
          next_r.cmd   = pwdata[1:0];
          next_r.state = hmap_pkg::HMAP_H_WAITACK;
        end
        else if (access && pwrite && paddr == `HMAP_REG_ARG)
        begin
          next_r.arg = pwdata[15:0];
        end
      end
      hmap_pkg::HMAP_H_WAITACK:
      begin
        if (!link.host_acknowledge_n)
        begin
          next_r.state = hmap_pkg::HMAP_H_STROBE;
          next_r.sel_n = 1'b0;
          next_r.cnt   = 2'h1;
          next_r.al    = r.cmd == `HMAP_CMD_LATCH;
          next_r.wr_n  = r.cmd != `HMAP_CMD_WRITE;
          next_r.rd_n  = r.cmd != `HMAP_CMD_READ;
          next_r.oe_n  = r.cmd == `HMAP_CMD_READ;
        end
      end
      hmap_pkg::HMAP_H_STROBE:
      begin
        next_r.cnt = r.cnt + 2'h1;
        if (r.cmd == `HMAP_CMD_LATCH && r.cnt >= 2'(`HMAP_LATCH_CYC))
        begin
          next_r.state = hmap_pkg::HMAP_H_END;
          next_r.al    = 1'b0;
          next_r.sel_n = 1'b1;
        end
        else if (r.cmd != `HMAP_CMD_LATCH
                 && r.cnt >= 2'(`HMAP_STROBE_CYC))
        begin
          next_r.state = hmap_pkg::HMAP_H_ACKW;
        end
      end
      hmap_pkg::HMAP_H_ACKW:
      begin
        if (!link.host_acknowledge_n)
        begin
          // long cycles only: strobe outlives the acknowledge edge
          next_r.state = hmap_pkg::HMAP_H_END;
          next_r.sel_n = 1'b1;
          next_r.wr_n  = 1'b1;
          next_r.rd_n  = 1'b1;
          if (r.cmd == `HMAP_CMD_READ)
          begin
            next_r.rdata = link.host_addr_data_bus;
          end
        end
      end
      hmap_pkg::HMAP_H_END:
      begin
        next_r.oe_n  = 1'b1;
        next_r.state = hmap_pkg::HMAP_H_IDLE;
      end
      default:
      begin
        next_r.state = hmap_pkg::HMAP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r       <= '0;
      r.sel_n <= 1'b1;
      r.wr_n  <= 1'b1;
      r.rd_n  <= 1'b1;
      r.oe_n  <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign prdata                   = r.prdata;
  assign pslverr                  = r.pslverr && access;
  assign pready                   = 1'b1;
  assign link.host_port_select_n  = r.sel_n;
  assign link.host_write_strobe_n = r.wr_n;
  assign link.host_read_strobe_n  = r.rd_n;
  assign link.host_address_latch  = r.al;
  assign link.host_ad_out         = r.arg;
  assign link.host_ad_oe_n        = r.oe_n;
endmodule

// ---- testbench/hmap_asserts.sv ----
// checker for the link pins between host end and device end
// assumes one pclk domain, presetn async low, instanced beside the link
module hmap_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        host_port_select_n,
  input wire logic        host_write_strobe_n,
  input wire logic        host_read_strobe_n,
  input wire logic        host_address_latch,
  input wire logic        host_acknowledge_n,
  input wire logic        host_ad_oe_n,
  input wire logic        dev_ad_oe_n,
  input wire logic [15:0] dev_ad_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire rd_on = !host_port_select_n && !host_read_strobe_n;
  wire wr_on = !host_port_select_n && !host_write_strobe_n;

  sequence s_rd_start;
    $rose(rd_on) && !host_acknowledge_n;
  endsequence
  sequence s_wr_start;
    $rose(wr_on) && !host_acknowledge_n;
  endsequence
  // busy must be seen before ack may come back low
  sequence s_wr_ack;
    ##1 host_acknowledge_n ##[1:6] !host_acknowledge_n;
  endsequence

  property p_rd_busy;
    s_rd_start |-> ##[1:2] host_acknowledge_n;
  endproperty
  property p_rd_prev;
    s_rd_start |-> ##[1:2] !dev_ad_oe_n;
  endproperty
  property p_wr_ack;
    s_wr_start |=> s_wr_ack;
  endproperty
  property p_ack_data;
    $fell(host_acknowledge_n) && rd_on |-> !dev_ad_oe_n && $stable(dev_ad_out);
  endproperty
  property p_rd_hold;
    rd_on && !dev_ad_oe_n |=> !rd_on || !dev_ad_oe_n;
  endproperty
  property p_rd_release;
    $fell(rd_on) && !dev_ad_oe_n |-> ##[1:2] dev_ad_oe_n;
  endproperty
  property p_rd_order;
    $rose(rd_on) |-> !host_acknowledge_n;
  endproperty
  property p_wr_order;
    $rose(wr_on) |-> !host_acknowledge_n;
  endproperty
  property p_latch_drive;
    !host_port_select_n && host_address_latch |-> !host_ad_oe_n && dev_ad_oe_n;
  endproperty

  a_rd_busy: assert property (p_rd_busy)
    else $error("ack not high after read start");
  a_rd_prev: assert property (p_rd_prev)
    else $error("previous word not driven at read start");
  a_wr_ack: assert property (p_wr_ack)
    else $error("write ack too early or missing");
  a_ack_data: assert property (p_ack_data)
    else $error("read word not settled before ack low");
  a_rd_hold: assert property (p_rd_hold)
    else $error("bus released during read");
  a_rd_release: assert property (p_rd_release)
    else $error("bus not released after read end");
  a_rd_order: assert property (p_rd_order)
    else $error("read started while ack high");
  a_wr_order: assert property (p_wr_order)
    else $error("write started while ack high");
  a_latch_drive: assert property (p_latch_drive)
    else $error("address not driven by host during latch");
endmodule

// ---- testbench/hmap_bench.sv ----
// self-checking bench: APB commands drive host end against device end
// assumes design files and hmap_params.svh compiled before this file
`include "hmap_params.svh"

module hmap_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mode_strap;
  logic        core_ovl_wr;
  logic [15:0] core_ovl_wdata;
  logic [15:0] ovl_value;
  logic        port_enabled;
  logic        port_busy;
  logic [31:0] q;
  logic        err;
  logic [15:0] d;
  int          failures;
  int          comparisons;

  hmap_if link();
  hmap_host hmap_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  hmap_device hmap_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .mode_strap(mode_strap), .core_ovl_wr(core_ovl_wr),
    .core_ovl_wdata(core_ovl_wdata), .ovl_value(ovl_value),
    .port_enabled(port_enabled), .port_busy(port_busy));
  hmap_asserts hmap_asserts_inst (.pclk(pclk), .presetn(presetn),
    .host_port_select_n(link.host_port_select_n),
    .host_write_strobe_n(link.host_write_strobe_n),
    .host_read_strobe_n(link.host_read_strobe_n),
    .host_address_latch(link.host_address_latch),
    .host_acknowledge_n(link.host_acknowledge_n),
    .host_ad_oe_n(link.host_ad_oe_n), .dev_ad_oe_n(link.dev_ad_oe_n),
    .dev_ad_out(link.dev_ad_out));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd_q,
                     output logic rd_e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // polling is bounded; a stuck busy flag counts as a mismatch
  task automatic cmd(input logic [1:0] c, input logic [15:0] a);
    int i;
    apb(1'b1, `HMAP_REG_ARG, {16'h0000, a}, q, err);
    apb(1'b1, `HMAP_REG_CMD, {30'h00000000, c}, q, err);
    for (i = 0; i < 64; i++)
    begin
      apb(1'b0, `HMAP_REG_STATUS, 32'h00000000, q, err);
      if (q[0] === 1'b0)
        break;
    end
    chk("busy after poll", 16'h0000, {15'h0000, q[0]});
  endtask

  task automatic rd(output logic [15:0] v);
    cmd(`HMAP_CMD_READ, 16'h0000);
    apb(1'b0, `HMAP_REG_RDATA, 32'h00000000, q, err);
    v = q[15:0];
  endtask

  task automatic core_wr(input logic [15:0] v);
    @(posedge pclk);
    core_ovl_wr <= 1'b1;
    core_ovl_wdata <= v;
    @(posedge pclk);
    core_ovl_wr <= 1'b0;
    @(posedge pclk);
  endtask

  task final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    mode_strap = 1'b1;
    core_ovl_wr = 1'b0;
    core_ovl_wdata = 16'h0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("port_enabled", 16'h0001, {15'h0000, port_enabled});
    chk("overlay reset", `HMAP_OVL_RESET, ovl_value);
    $display("test reset done");
    // data words, then long reads that return the word just fetched
    cmd(`HMAP_CMD_LATCH, 16'h4010);
    cmd(`HMAP_CMD_WRITE, 16'h1234);
    cmd(`HMAP_CMD_WRITE, 16'h5678);
    cmd(`HMAP_CMD_LATCH, 16'h4010);
    rd(d);
    chk("first read", 16'h1234, d);
    rd(d);
    chk("data read", 16'h5678, d);
    $display("test data memory done");
    // program word in two halves
    cmd(`HMAP_CMD_LATCH, 16'h0020);
    cmd(`HMAP_CMD_WRITE, 16'hABCD);
    cmd(`HMAP_CMD_WRITE, 16'h00EF);
    cmd(`HMAP_CMD_LATCH, 16'h0020);
    rd(d);
    chk("upper half", 16'hABCD, d);
    rd(d);
    chk("lower half", 16'h00EF, {8'h00, d[7:0]});
    cmd(`HMAP_CMD_LATCH, 16'h4011);
    rd(d);
    chk("data after program", 16'h5678, d);
    $display("test program memory done");
    // overlay written by core, then by host, then read in short-only mode
    core_wr(16'h4000);
    chk("core overlay", 16'h4000, ovl_value);
    cmd(`HMAP_CMD_LATCH, 16'h7FE7);
    cmd(`HMAP_CMD_WRITE, 16'h4002);
    chk("host overlay", 16'h4002, ovl_value);
    cmd(`HMAP_CMD_LATCH, 16'h7FE7);
    rd(d);
    chk("previous word", 16'h5678, d);
    cmd(`HMAP_CMD_LATCH, 16'h4010);
    rd(d);
    chk("overlay read", 16'h4002, d);
    rd(d);
    chk("short-only read", 16'h1234, d);
    $display("test overlay done");
    apb(1'b0, 12'h010, 32'h00000000, q, err);
    chk("unmapped error", 16'h0001, {15'h0000, err});
    chk("unmapped data", 16'h0000, q[15:0]);
    $display("test unmapped done");
    // strap low: port stays off and never acknowledges
    presetn <= 1'b0;
    mode_strap <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("strap off", 16'h0000, {15'h0000, port_enabled});
    chk("ack off", 16'h0001, {15'h0000, link.host_acknowledge_n});
    chk("overlay cleared", `HMAP_OVL_RESET, ovl_value);
    $display("test strap off done");
    final_report();
  end

  // whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end
endmodule
